/* File: core/ssprx_slave.sv */
// Purpose: serial port I2C slave-receive end with control_reg_one
// Assumes: pins cross via two flops; APB slave with zero wait states
// Notes: slave transmit and master sequencing are outside this block
// Contract
// - Matching write address: clear rw, buffer, ack
// - Full or overflow on address gives nack; with address hold on the code drives the software ack value instead
// - Flag every byte; software clears it; outside hold modes the code flags only acked bytes, so a nacked byte sets no flag
// - Stretch enable holds SCL after bytes
// - Start sets start bit, optional interrupt
// - Buffer read clears buffer-full flag
// - Stop sets stop bit, bus idle
// - Hold modes flag, stretch after eighth fall
// - Ack-time bit shows flag before/after ack
// - Software ack value driven after release
// - Flag after ninth fall on ack only
// - Hold plus stretch stretches after ack
// - Nack or stop ends the transfer
// - Invalid buffer write sets collision flag
// - New byte over full buffer: overflow
// - Enable bit gives port the pins
// - Clock release bit: polarity or SCL hold
// - Mode field selects SPI master/slave modes; SPI codes only reach port_mode here
// - Software avoids zero baud divider values
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module ssprx_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic port_irq,
  output logic [3:0] port_mode,
  ssprx_if.slave bus
);
  typedef enum logic [1:0] {IDLE, SHIFT, ACKB, IGNORE} ssprx_st_type;
  ssprx_st_type st_r;
  logic [7:0] ctrl1_r, ctrl2_r, buf_r, sr_r;
  logic [6:0] own_addr_r;
  logic [3:0] cnt_r;
  logic bf_r, rw_r, start_r, stop_r, ack_time_status_r, if_r, da_r;
  logic is_addr_r, ack_r, sda_oe_n_r, scl_oe_n_r;
  logic [1:0] scl_s, sda_s;
  logic scl_q, sda_q;
  logic wr_en, rd_en, scl_rise, scl_fall, start_det, stop_det;
  logic i2c_slave, hold, stretch_byte, nack_now;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], bus.scl};
      sda_s <= {sda_s[0], bus.sda};
      scl_q <= scl_s[1];
      sda_q <= sda_s[1];
    end
  end
  assign scl_rise = scl_s[1] & ~scl_q;
  assign scl_fall = ~scl_s[1] & scl_q;
  assign start_det = scl_s[1] & scl_q & sda_q & ~sda_s[1];
  assign stop_det = scl_s[1] & scl_q & ~sda_q & sda_s[1];
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  // only the 7-bit I2C slave codes (S7, S7I) run this receive path
  assign i2c_slave = ctrl1_r[ssprx_pkg::B_EN] &
    (ctrl1_r[3:0] == ssprx_pkg::M_I2C_S7 ||
     ctrl1_r[3:0] == ssprx_pkg::M_I2C_S7I);
  assign hold = is_addr_r ? ctrl2_r[ssprx_pkg::B_ADDRESS_HOLD_ENABLE]
                          : ctrl2_r[ssprx_pkg::B_DATA_HOLD_ENABLE];
  // Address ack refused while buffer occupied or overflow set, unless address hold is on
  assign nack_now = bf_r | ctrl1_r[ssprx_pkg::B_RECEIVE_OVERFLOW_FLAG];
  assign stretch_byte = ctrl2_r[ssprx_pkg::B_SEN] & ~hold;
  // Bit-level receive state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= IDLE;
      cnt_r <= 4'h0;
      sr_r <= 8'h00;
      is_addr_r <= 1'b0;
      ack_r <= 1'b0;
    end else if (!i2c_slave || stop_det) begin
      st_r <= IDLE;
    end else if (start_det) begin
      st_r <= SHIFT;
      cnt_r <= 4'h0;
      is_addr_r <= 1'b1;
    end else begin
      case (st_r)
        SHIFT: begin
          if (scl_rise) begin
            sr_r <= {sr_r[6:0], sda_s[1]};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            if (is_addr_r && (sr_r[7:1] != own_addr_r || sr_r[0])) begin
              st_r <= IGNORE;
            end else begin
              st_r <= ACKB;
              ack_r <= hold ? 1'b1 : (is_addr_r ? ~nack_now : ~bf_r);
            end
          end
        end
        ACKB: begin
          if (scl_fall) begin
            // nack ends the transfer
            // Follow what was really driven, a software nack included
            st_r <= !sda_oe_n_r ? SHIFT : IGNORE;
            cnt_r <= 4'h0;
            is_addr_r <= 1'b0;
          end
        end
        default: st_r <= st_r;
      endcase
    end
  end
  // Ack set while SCL is low, so SDA is steady before SCL is released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_oe_n_r <= 1'b1;
    end else if (st_r == ACKB && ack_r && scl_q == 1'b0) begin
      sda_oe_n_r <= hold ? ctrl2_r[ssprx_pkg::B_ACK_DATA_VALUE] : 1'b0;
    end else if (st_r != ACKB) begin
      sda_oe_n_r <= 1'b1;
    end
  end
  // in slave mode the release bit drives SCL
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe_n_r <= 1'b1;
    end else begin
      scl_oe_n_r <= ~i2c_slave | ctrl1_r[ssprx_pkg::B_CKP];
    end
  end
  assign bus.sda_s_oe_n = sda_oe_n_r;
  assign bus.scl_s_oe_n = scl_oe_n_r;
  // control_reg_one; hardware sets win over software clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_r <= ssprx_pkg::CTRL1_RESET;
    end else begin
      if (wr_en && paddr == ssprx_pkg::OFF_CTRL1) begin
        ctrl1_r <= pwdata[7:0];
      end
      if (i2c_slave && st_r == SHIFT && scl_fall && cnt_r == 4'h8) begin
        if (!is_addr_r || sr_r == {own_addr_r, 1'b0}) begin
          if (hold) begin
            ctrl1_r[ssprx_pkg::B_CKP] <= 1'b0;
          end else if (ctrl2_r[ssprx_pkg::B_SEN]) begin
            ctrl1_r[ssprx_pkg::B_CKP] <= 1'b0;
          end
          if (bf_r) begin
            ctrl1_r[ssprx_pkg::B_RECEIVE_OVERFLOW_FLAG] <= 1'b1;
          end
        end
      end
      if (st_r == ACKB && scl_fall && !sda_oe_n_r && hold
          && stretch_byte == 1'b0
          && ctrl2_r[ssprx_pkg::B_SEN]) begin
        ctrl1_r[ssprx_pkg::B_CKP] <= 1'b0;
      end
      if (wr_en && paddr == ssprx_pkg::OFF_BUF && st_r == SHIFT &&
          cnt_r != 4'h0) begin
        ctrl1_r[ssprx_pkg::B_WRITE_COLLISION_FLAG] <= 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl2_r <= ssprx_pkg::CTRL2_RESET;
      own_addr_r <= ssprx_pkg::DEF_ADDR;
    end else if (wr_en) begin
      if (paddr == ssprx_pkg::OFF_CTRL2) begin
        ctrl2_r <= pwdata[7:0];
      end else if (paddr == ssprx_pkg::OFF_ADDR) begin
        own_addr_r <= pwdata[6:0];
      end
    end
  end
  // Buffer, buffer-full and status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_r <= 8'h00;
      bf_r <= 1'b0;
      rw_r <= 1'b0;
      da_r <= 1'b0;
      ack_time_status_r <= 1'b0;
    end else begin
      if (rd_en && paddr == ssprx_pkg::OFF_BUF) begin
        bf_r <= 1'b0;
      end
      if (i2c_slave && st_r == SHIFT && scl_fall && cnt_r == 4'h8) begin
        ack_time_status_r <= 1'b1;
        if (is_addr_r && sr_r == {own_addr_r, 1'b0} && !nack_now) begin
          buf_r <= sr_r;
          bf_r <= 1'b1;
          rw_r <= 1'b0;
          da_r <= 1'b0;
        end else if (!is_addr_r && !bf_r) begin
          buf_r <= sr_r;
          bf_r <= 1'b1;
          da_r <= 1'b1;
        end
      end else if (st_r == ACKB && scl_fall) begin
        ack_time_status_r <= 1'b0;
      end
    end
  end
  // Start, stop and interrupt flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= 1'b0;
      stop_r <= 1'b0;
      if_r <= 1'b0;
    end else begin
      if (wr_en && paddr == ssprx_pkg::OFF_STAT) begin
        if (pwdata[ssprx_pkg::B_IF]) begin
          if_r <= 1'b0;
        end
      end
      if (i2c_slave && start_det) begin
        start_r <= 1'b1;
        stop_r <= 1'b0;
        if (ctrl1_r[3:0] == ssprx_pkg::M_I2C_S7I) begin
          if_r <= 1'b1;
        end
      end
      if (i2c_slave && stop_det) begin
        stop_r <= 1'b1;
        start_r <= 1'b0;
        if (ctrl1_r[3:0] == ssprx_pkg::M_I2C_S7I) begin
          if_r <= 1'b1;
        end
      end
      if (i2c_slave && st_r == SHIFT && scl_fall && cnt_r == 4'h8 &&
          hold && (!is_addr_r || sr_r == {own_addr_r, 1'b0})) begin
        if_r <= 1'b1;
      end
      if (st_r == ACKB && scl_fall && sda_s[1] == 1'b0) begin
        if_r <= 1'b1;
      end
    end
  end
  // APB read mux, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (paddr == ssprx_pkg::OFF_CTRL1) begin
          prdata <= {24'h00_0000, ctrl1_r};
        end else if (paddr == ssprx_pkg::OFF_CTRL2) begin
          prdata <= {24'h00_0000, ctrl2_r};
        end else if (paddr == ssprx_pkg::OFF_STAT) begin
          prdata <= {25'h000_0000, da_r, if_r, ack_time_status_r, stop_r,
                     start_r, rw_r, bf_r};
        end else if (paddr == ssprx_pkg::OFF_BUF) begin
          prdata <= {24'h00_0000, buf_r};
        end else if (paddr == ssprx_pkg::OFF_ADDR) begin
          prdata <= {25'h000_0000, own_addr_r};
        end else begin
          pslverr <= 1'b1;
        end
      end else if (psel && !penable && paddr > ssprx_pkg::OFF_ADDR) begin
        pslverr <= 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_irq <= 1'b0;
      port_mode <= 4'h0;
    end else begin
      port_irq <= if_r;
      port_mode <= ctrl1_r[3:0];
    end
  end
endmodule : ssprx_slave

/* File: inc/ssprx_pkg.sv */
// Purpose: shared constants for the serial port I2C slave-receive pair
// Assumes: 10 MHz pclk, APB with 32-bit data on both ends
// Notes: offsets are byte addresses of one aligned word each
package ssprx_pkg;
  // Register offsets
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_BUF = 8'h0C;
  localparam logic [7:0] OFF_ADDR = 8'h10;
  localparam logic [7:0] OFF_MCMD = 8'h14;
  localparam logic [7:0] OFF_MSTAT = 8'h18;
  localparam logic [7:0] OFF_MRX = 8'h1C;
  // control_reg_one fields
  localparam int B_WRITE_COLLISION_FLAG = 7;
  localparam int B_RECEIVE_OVERFLOW_FLAG = 6;
  localparam int B_EN = 5;
  localparam int B_CKP = 4;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  // control_reg_two fields
  localparam int B_SEN = 0;
  localparam int B_ADDRESS_HOLD_ENABLE = 1;
  localparam int B_DATA_HOLD_ENABLE = 2;
  localparam int B_ACK_DATA_VALUE = 3;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  // Status fields
  localparam int B_BF = 0;
  localparam int B_RW = 1;
  localparam int B_START = 2;
  localparam int B_STOP = 3;
  localparam int B_ACK_TIME_STATUS = 4;
  localparam int B_IF = 5;
  localparam int B_DA = 6;
  // Mode codes
  localparam logic [3:0] M_SPI_M4 = 4'h0;
  localparam logic [3:0] M_SPI_M16 = 4'h1;
  localparam logic [3:0] M_SPI_M64 = 4'h2;
  localparam logic [3:0] M_SPI_MTMR = 4'h3;
  localparam logic [3:0] M_SPI_SSS = 4'h4;
  localparam logic [3:0] M_SPI_SNS = 4'h5;
  localparam logic [3:0] M_I2C_S7 = 4'h6;
  localparam logic [3:0] M_I2C_S10 = 4'h7;
  localparam logic [3:0] M_I2C_M = 4'h8;
  localparam logic [3:0] M_SPI_MBRG = 4'hA;
  localparam logic [3:0] M_I2C_FW = 4'hB;
  localparam logic [3:0] M_I2C_S7I = 4'hE;
  localparam logic [3:0] M_I2C_S10I = 4'hF;
  // Host command codes (bits 9:8 of command word)
  localparam logic [1:0] CMD_START = 2'h1;
  localparam logic [1:0] CMD_BYTE = 2'h2;
  localparam logic [1:0] CMD_STOP = 2'h3;
  // Bus timing
  localparam int CLK_HZ = 10_000_000;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam logic [6:0] DEF_ADDR = 7'h2A;
endpackage : ssprx_pkg

/* File: inc/ssprx_if.sv */
// Purpose: two-wire link between master end and slave end
// Assumes: open-drain wires resolved here from enables
// Notes: oe low means the end pulls the wire low
`timescale 1ns/1ps
interface ssprx_if;
  logic scl_m_oe_n;
  logic sda_m_oe_n;
  logic scl_s_oe_n;
  logic sda_s_oe_n;
  logic scl;
  logic sda;
  assign scl = scl_m_oe_n & scl_s_oe_n;
  assign sda = sda_m_oe_n & sda_s_oe_n;
  modport master (output scl_m_oe_n, output sda_m_oe_n, input scl, input sda);
  modport slave (output scl_s_oe_n, output sda_s_oe_n, input scl, input sda);
endinterface : ssprx_if

/* File: core/ssprx_master.sv */
// Purpose: two-wire master end driving start, bytes and stop
// Assumes: APB command register; SCL half period from package
// Notes: waits while the slave stretches SCL
`timescale 1ns/1ps
module ssprx_master (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ssprx_if.master bus
);
  typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_ACK, M_STOP}
    ssprx_mst_type;
  ssprx_mst_type st_r;
  logic [15:0] tmr_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic phase_r, busy_r, nack_r, scl_r, sda_r;
  logic [1:0] scl_s, sda_s;
  logic [1:0] cmd_r;
  logic tick, cmd_wr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
    end else begin
      scl_s <= {scl_s[0], bus.scl};
      sda_s <= {sda_s[0], bus.sda};
    end
  end
  assign tick = (tmr_r == 16'h0000);
  assign cmd_wr = psel & penable & pwrite & ~busy_r &
                  (paddr == ssprx_pkg::OFF_MCMD);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= M_IDLE;
      tmr_r <= 16'h0000;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      phase_r <= 1'b0;
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      cmd_r <= 2'h0;
    end else begin
      if (!tick) begin
        // Stretch: hold count while SCL released but low
        if (!(scl_r && !scl_s[1])) begin
          tmr_r <= tmr_r - 16'h0001;
        end
      end
      case (st_r)
        M_IDLE: begin
          if (cmd_wr) begin
            cmd_r <= pwdata[9:8];
            sh_r <= pwdata[7:0];
            busy_r <= 1'b1;
            bit_r <= 4'h0;
            phase_r <= 1'b0;
            tmr_r <= 16'(ssprx_pkg::SCL_HALF_CYC);
            if (pwdata[9:8] == ssprx_pkg::CMD_START) begin
              st_r <= M_START;
            end else if (pwdata[9:8] == ssprx_pkg::CMD_BYTE) begin
              st_r <= M_BIT;
            end else begin
              st_r <= M_STOP;
            end
          end
        end
        M_START: begin
          if (tick) begin
            if (!phase_r) begin
              sda_r <= 1'b1;
              scl_r <= 1'b1;
              phase_r <= 1'b1;
            end else if (sda_r) begin
              sda_r <= 1'b0;
            end else begin
              scl_r <= 1'b0;
              st_r <= M_IDLE;
              busy_r <= 1'b0;
            end
            tmr_r <= 16'(ssprx_pkg::SCL_HALF_CYC);
          end
        end
        M_BIT: begin
          if (tick) begin
            // Data set, SCL high, then fall and shift
            if (scl_r) begin
              scl_r <= 1'b0;
              sh_r <= {sh_r[6:0], 1'b0};
              bit_r <= bit_r + 4'h1;
              phase_r <= 1'b0;
              if (bit_r == 4'h7) begin
                st_r <= M_ACK;
                sda_r <= 1'b1;
              end
            end else if (!phase_r) begin
              sda_r <= sh_r[7];
              phase_r <= 1'b1;
            end else begin
              scl_r <= 1'b1;
            end
            tmr_r <= 16'(ssprx_pkg::SCL_HALF_CYC);
          end
        end
        M_ACK: begin
          if (tick) begin
            if (!scl_r && phase_r) begin
              scl_r <= 1'b1;
            end else if (scl_r) begin
              nack_r <= sda_s[1];
              scl_r <= 1'b0;
              st_r <= M_IDLE;
              busy_r <= 1'b0;
            end
            phase_r <= ~phase_r;
            tmr_r <= 16'(ssprx_pkg::SCL_HALF_CYC);
          end
        end
        default: begin
          if (tick) begin
            if (!phase_r) begin
              sda_r <= 1'b0;
              scl_r <= 1'b0;
              phase_r <= 1'b1;
            end else if (!scl_r) begin
              scl_r <= 1'b1;
            end else begin
              sda_r <= 1'b1;
              st_r <= M_IDLE;
              busy_r <= 1'b0;
            end
            tmr_r <= 16'(ssprx_pkg::SCL_HALF_CYC);
          end
        end
      endcase
    end
  end
  assign bus.scl_m_oe_n = scl_r;
  assign bus.sda_m_oe_n = sda_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        if (paddr == ssprx_pkg::OFF_MSTAT) begin
          prdata <= {28'h000_0000, cmd_r, nack_r, busy_r};
        end else if (paddr == ssprx_pkg::OFF_MRX) begin
          prdata <= {24'h00_0000, sh_r};
        end else if (paddr != ssprx_pkg::OFF_MCMD) begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule : ssprx_master

/* File: dv/ssprx_chk.sv */
// Purpose: wire checks on the two-wire link between both ends
// Assumes: pclk oversamples the wires; both ends are design code
// Notes: fall counter restarts at each start condition
`timescale 1ns/1ps
module ssprx_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_m_oe_n,
  input wire logic sda_m_oe_n,
  input wire logic scl_s_oe_n,
  input wire logic sda_s_oe_n,
  input wire logic scl,
  input wire logic sda
);
  logic scl_d_r;
  logic sda_d_r;
  logic busy_r;
  logic [3:0] fall_cnt_r;
  wire start_w = scl && scl_d_r && sda_d_r && !sda;
  wire stop_w = scl && scl_d_r && !sda_d_r && sda;
  wire fall_w = scl_d_r && !scl;

  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end

  // Start parks on F so its own SCL fall counts as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      fall_cnt_r <= 4'hF;
    else if (start_w)
      fall_cnt_r <= 4'hF;
    else if (fall_w)
      fall_cnt_r <= (fall_cnt_r >= 4'h8) ? 4'h0 : fall_cnt_r + 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      busy_r <= 1'b0;
    else if (start_w)
      busy_r <= 1'b1;
    else if (stop_w)
      busy_r <= 1'b0;
  end

  sequence s_ninth_fall;
    fall_w && fall_cnt_r == 4'h8;
  endsequence
  sequence s_sda_freed;
    ##[1:12] sda_s_oe_n;
  endsequence

  a_ack_in_slot: assert property ($fell(sda_s_oe_n) |->
    !scl && fall_cnt_r == 4'h8) else $error("SDA pulled outside ack slot");
  a_ack_freed: assert property (s_ninth_fall |-> s_sda_freed)
    else $error("ack not released after ninth fall");
  a_sda_low_phase: assert property ($changed(sda_s_oe_n) |-> !scl)
    else $error("slave moved SDA while SCL high");
  a_stretch_slot: assert property ($fell(scl_s_oe_n) |->
    !scl && (fall_cnt_r == 4'h8 || fall_cnt_r == 4'h0))
    else $error("stretch outside byte or ack boundary");
  a_stretch_min: assert property ($fell(scl_s_oe_n) |=>
    !scl_s_oe_n [*3]) else $error("stretch released too soon");
  a_idle_quiet: assert property (!busy_r |->
    sda_s_oe_n && scl_s_oe_n) else $error("slave drives idle bus");
  a_scl_high_min: assert property ($rose(scl) |=> scl [*8])
    else $error("SCL high phase too short");
  a_scl_low_min: assert property ($fell(scl) |=> !scl [*8])
    else $error("SCL low phase too short");
endmodule : ssprx_chk

/* File: dv/tb.sv */
// Purpose: self-checking bench for the I2C slave-receive pair
// Assumes: one APB master per end; ends joined by ssprx_if
// Notes: checked reads are judged by a monitor from queued notes
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [1:0] psel = 2'h0;
  logic [1:0] penable = 2'h0;
  logic [1:0] pwrite = 2'h0;
  logic [1:0] mark = 2'h0;
  logic [7:0] paddr [2] = '{8'h00, 8'h00};
  logic [31:0] pwdata [2] = '{32'h0, 32'h0};
  wire [31:0] prdata [2];
  wire [1:0] pready;
  wire [1:0] pslverr;
  wire port_irq;
  wire [3:0] port_mode;
  logic [8:0] exp_q [$];
  logic [8:0] msk_q [$];
  logic [7:0] nam_q [$];
  logic [31:0] rdv;
  logic [6:0] own;
  logic [7:0] dat;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;

  always #50 pclk = ~pclk;

  ssprx_if link ();
  ssprx_slave i_ssprx_slave (.pclk(pclk), .presetn(presetn),
    .psel(psel[0]), .penable(penable[0]), .pwrite(pwrite[0]),
    .paddr(paddr[0]), .pwdata(pwdata[0]), .prdata(prdata[0]),
    .pready(pready[0]), .pslverr(pslverr[0]), .port_irq(port_irq),
    .port_mode(port_mode), .bus(link.slave));
  ssprx_master i_ssprx_master (.pclk(pclk), .presetn(presetn),
    .psel(psel[1]), .penable(penable[1]), .pwrite(pwrite[1]),
    .paddr(paddr[1]), .pwdata(pwdata[1]), .prdata(prdata[1]),
    .pready(pready[1]), .pslverr(pslverr[1]), .bus(link.master));
  ssprx_chk u_chk (.pclk(pclk), .presetn(presetn),
    .scl_m_oe_n(link.scl_m_oe_n), .sda_m_oe_n(link.sda_m_oe_n),
    .scl_s_oe_n(link.scl_s_oe_n), .sda_s_oe_n(link.sda_s_oe_n),
    .scl(link.scl), .sda(link.sda));

  task automatic ck(input string n, input logic [8:0] e, input logic [8:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : ck

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Request held until pready is sampled high, then released
  task automatic apb(input int b, input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic m);
    @(posedge pclk);
    psel[b] <= 1'b1;
    penable[b] <= 1'b0;
    pwrite[b] <= w;
    paddr[b] <= a;
    pwdata[b] <= d;
    mark[b] <= m;
    @(posedge pclk);
    penable[b] <= 1'b1;
    do @(posedge pclk);
    while (pready[b] !== 1'b1);
    rdv = prdata[b];
    psel[b] <= 1'b0;
    penable[b] <= 1'b0;
    mark[b] <= 1'b0;
  endtask : apb

  task automatic chk(input int b, input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] e, input logic er = 1'b0);
    exp_q.push_back({er, e & m});
    msk_q.push_back({1'b1, m});
    nam_q.push_back(a);
    apb(b, 1'b0, a, 32'h0, 1'b1);
  endtask : chk

  task automatic wr(input int b, input logic [7:0] a, input logic [7:0] d);
    apb(b, 1'b1, a, {24'h000000, d}, 1'b0);
  endtask : wr

  task automatic poll(input int b, input logic [7:0] a, input int n,
      input logic v);
    do apb(b, 1'b0, a, 32'h0, 1'b0);
    while (rdv[n] !== v);
  endtask : poll

  task automatic st(input logic [7:0] m, input logic [7:0] e);
    chk(0, ssprx_pkg::OFF_STAT, m, e);
  endtask : st

  task automatic c1(input logic [7:0] d);
    wr(0, ssprx_pkg::OFF_CTRL1, d);
  endtask : c1

  task automatic clr();
    wr(0, ssprx_pkg::OFF_STAT, 8'h20);
  endtask : clr

  task automatic wif();
    poll(0, ssprx_pkg::OFF_STAT, ssprx_pkg::B_IF, 1'b1);
  endtask : wif

  task automatic mdone();
    poll(1, ssprx_pkg::OFF_MSTAT, 0, 1'b0);
  endtask : mdone

  task automatic mc(input logic [1:0] c, input logic [7:0] d, input bit w);
    apb(1, 1'b1, ssprx_pkg::OFF_MCMD, {22'h000000, c, d}, 1'b0);
    if (w)
      mdone();
  endtask : mc

  always @(posedge pclk) begin
    for (int b = 0; b < 2; b++) begin
      if (mark[b] && penable[b] && pready[b] === 1'b1) begin
        ck($sformatf("reg %h", nam_q.pop_front()), exp_q.pop_front(),
          {pslverr[b], prdata[b][7:0]} & msk_q.pop_front());
      end
    end
  end

  // Whole run needs about 11000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(32'hF0CD));
    // Stay clear of reserved address groups
    own = {2'b01, 5'($urandom())};
    dat = 8'($urandom());
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk(0, ssprx_pkg::OFF_CTRL1, 8'hFF, 8'h00);
    chk(0, ssprx_pkg::OFF_CTRL2, 8'hFF, 8'h00);
    st(8'h7F, 8'h00);
    chk(0, 8'h20, 8'h00, 8'h00, 1'b1);
    for (int i = 0; i < 16; i++) begin
      if (i inside {9, 12, 13})
        continue;
      c1(8'(i));
      chk(0, ssprx_pkg::OFF_CTRL1, 8'h3F, 8'(i));
      ck("port_mode", 9'(i), {5'h00, port_mode});
    end
    wr(0, ssprx_pkg::OFF_ADDR, {1'b0, own});
    c1(8'h16);
    mc(ssprx_pkg::CMD_START, 8'h00, 1'b1);
    mc(ssprx_pkg::CMD_BYTE, {own, 1'b0}, 1'b1);
    chk(1, ssprx_pkg::OFF_MSTAT, 8'h02, 8'h02);
    mc(ssprx_pkg::CMD_STOP, 8'h00, 1'b1);
    st(8'h27, 8'h00);
    c1(8'h3E);
    mc(ssprx_pkg::CMD_START, 8'h00, 1'b1);
    st(8'h24, 8'h24);
    ck("port_irq", 9'h001, {8'h00, port_irq});
    clr();
    st(8'h20, 8'h00);
    mc(ssprx_pkg::CMD_BYTE, {own, 1'b0}, 1'b1);
    chk(1, ssprx_pkg::OFF_MSTAT, 8'h02, 8'h00);
    st(8'h23, 8'h21);
    chk(0, ssprx_pkg::OFF_BUF, 8'hFF, {own, 1'b0});
    st(8'h01, 8'h00);
    clr();
    mc(ssprx_pkg::CMD_BYTE, dat, 1'b1);
    st(8'h61, 8'h61);
    mc(ssprx_pkg::CMD_BYTE, ~dat, 1'b1);
    chk(0, ssprx_pkg::OFF_CTRL1, 8'h40, 8'h40);
    chk(0, ssprx_pkg::OFF_BUF, 8'hFF, dat);
    mc(ssprx_pkg::CMD_STOP, 8'h00, 1'b1);
    st(8'h08, 8'h08);
    mc(ssprx_pkg::CMD_START, 8'h00, 1'b1);
    mc(ssprx_pkg::CMD_BYTE, {own, 1'b0}, 1'b1);
    chk(1, ssprx_pkg::OFF_MSTAT, 8'h02, 8'h02);
    mc(ssprx_pkg::CMD_STOP, 8'h00, 1'b1);
    clr();
    c1(8'h3E);
    chk(0, ssprx_pkg::OFF_CTRL1, 8'h40, 8'h00);
    // Hold on address and data, stretch on
    c1(8'h36);
    wr(0, ssprx_pkg::OFF_CTRL2, 8'h07);
    mc(ssprx_pkg::CMD_START, 8'h00, 1'b1);
    clr();
    mc(ssprx_pkg::CMD_BYTE, {own, 1'b0}, 1'b0);
    wif();
    ck("scl", 9'h000, {8'h00, link.scl});
    chk(0, ssprx_pkg::OFF_CTRL1, 8'h10, 8'h00);
    st(8'h11, 8'h11);
    chk(0, ssprx_pkg::OFF_BUF, 8'hFF, {own, 1'b0});
    clr();
    c1(8'h36);
    wif();
    st(8'h10, 8'h00);
    ck("scl", 9'h000, {8'h00, link.scl});
    clr();
    c1(8'h36);
    mdone();
    chk(1, ssprx_pkg::OFF_MSTAT, 8'h02, 8'h00);
    mc(ssprx_pkg::CMD_BYTE, dat, 1'b0);
    wif();
    chk(0, ssprx_pkg::OFF_BUF, 8'hFF, dat);
    wr(0, ssprx_pkg::OFF_CTRL2, 8'h0F);
    clr();
    c1(8'h36);
    mdone();
    chk(1, ssprx_pkg::OFF_MSTAT, 8'h02, 8'h02);
    st(8'h20, 8'h00);
    mc(ssprx_pkg::CMD_STOP, 8'h00, 1'b1);
    st(8'h08, 8'h08);
    tally_and_finish();
  end
endmodule : tb
